// [design/vcs_slave.v]
`timescale 1ns/1ps
`include "vcs_defs.vh"

module vcs_slave #(
  parameter [7:0] ROM_CHECKSUM = 8'h00,
  parameter [23:0] ROM_LENGTH = 24'h000000,
  parameter [23:0] MAKER_ID = 24'h000001,       // Arbitrary value
  parameter [31:0] BOARD_IDENTIFIER = 32'h00000001,     // Arbitrary value
  parameter [31:0] BOARD_REV = 32'h00000001,    // Arbitrary value
  parameter [7:0] INTR_CAP = 8'h00,
  parameter [31:0] F0_DEC_MASK = 32'hF8000000,
  parameter [31:0] FW_REVISION = 32'h00000001   // Arbitrary value
) (
  // Clock and reset
  input wire ref_clk_in,
  input wire sys_rst_in,
  // Bus address phase
  input wire [31:0] addr_in,
  input wire [5:0] am_in,
  input wire as_n_in,
  input wire lword_n_in,
  input wire write_n_in,
  input wire [1:0] ds_n_in,
  input wire [4:0] ga_n_in,
  // Bus data, two-way
  input wire [31:0] data_in,
  output reg [31:0] data_out,
  output reg data_oe_out,
  // Data acknowledge, open drain
  output reg dtack_n_out,
  output reg dtack_oe_out,
  // Module side
  input wire [31:0] unit_number_in,
  input wire [31:0] status_in,
  output reg [31:0] addressing_control_out,
  output reg [9:0] reset_pulse_out
);

  localparam ST_IDLE = 2'd0;
  localparam ST_ACK = 2'd1;
  localparam ST_BLK = 2'd2;
  localparam integer PULSE_CYC = (`VCS_PULSE_NS + `VCS_CLK_NS - 1) / `VCS_CLK_NS;
  localparam [3:0] PULSE_LAST = PULSE_CYC[3:0] - 4'h1;

  reg [1:0] state_q;
  reg [31:0] addr_q;
  reg [5:0] am_q;
  reg as_prev_q;
  reg [7:0] base_addr_q;
  reg [7:0] csr_bits_q;
  reg [31:0] f0_compare_q;
  reg [31:0] status_snap_q;
  reg [3:0] pulse_cnt_q;
  reg [31:0] rd_w;
  reg [3:0] be;
  reg [31:0] wd;
  reg [31:0] rd_lane;

  wire [18:0] cfg_byte = {addr_q[18:2], 2'b11};
  wire [18:0] cfg_word = {addr_q[18:2], 2'b00};
  wire [26:0] nrm_word = {addr_q[26:2], 2'b00};
  wire is_blk = (am_q == `VCS_AM_A32_BLK);
  wire cfg_sel = (am_q == `VCS_AM_CFG) && (addr_q[23:19] == ~ga_n_in);
  wire nrm_sel = ((am_q == `VCS_AM_A32_SGL) || is_blk) &&
                 csr_bits_q[`VCS_BIT_MOD_ENABLE] &&
                 (addr_q[31:27] == f0_compare_q[31:27]);
  wire ds_act = (ds_n_in != 2'b11);
  wire strobe = !as_n_in && !as_prev_q && ds_act && (cfg_sel || nrm_sel);
  wire go = strobe && (state_q != ST_ACK);
  wire wr = go && !write_n_in;

  // Reads one byte of configuration ROM, MSB first per multi-byte field
  function [7:0] fld_byte;
    input [63:0] val;
    input [18:0] a;
    input [18:0] base;
    input [3:0] len;
    reg [18:0] k;
    integer sh;
    begin
      k = (a - base) >> 2;
      fld_byte = 8'h00;
      // Shift worked out at integer width; a 4-bit product would wrap past byte 1
      sh = len;
      sh = (sh - 1 - k[3:0]) * 8;
      if ((a >= base) && (k < {15'h0000, len}))
      begin
        fld_byte = val[sh +: 8];
      end
    end
  endfunction

  // Byte-wide ROM, one byte at each fourth address; gaps read zero
  function [7:0] rom_byte;
    input [18:0] a;
    begin
      rom_byte = fld_byte({56'h0, ROM_CHECKSUM}, a, `VCS_OFF_ROM_CHECKSUM, 4'd1) |
        fld_byte({40'h0, ROM_LENGTH}, a, `VCS_OFF_ROM_LENGTH, 4'd3) |
        fld_byte({56'h0, `VCS_VAL_ACC_W}, a, `VCS_OFF_ROM_ACC_W, 4'd1) |
        fld_byte({56'h0, `VCS_VAL_ACC_W}, a, `VCS_OFF_CSR_ACC_W, 4'd1) |
        fld_byte({56'h0, `VCS_VAL_SPACE_VER}, a, `VCS_OFF_SPACE_VER, 4'd1) |
        fld_byte({56'h0, `VCS_VAL_ASCII_C}, a, `VCS_OFF_ASCII_C, 4'd1) |
        fld_byte({56'h0, `VCS_VAL_ASCII_R}, a, `VCS_OFF_ASCII_R, 4'd1) |
        fld_byte({40'h0, MAKER_ID}, a, `VCS_OFF_MAKER_ID, 4'd3) |
        fld_byte({32'h0, BOARD_IDENTIFIER}, a, `VCS_OFF_BOARD_IDENTIFIER, 4'd4) |
        fld_byte({32'h0, BOARD_REV}, a, `VCS_OFF_BOARD_REV, 4'd4) |
        fld_byte({40'h0, `VCS_VAL_USER_START}, a, `VCS_OFF_USER_START, 4'd3) |
        fld_byte({40'h0, `VCS_VAL_USER_END}, a, `VCS_OFF_USER_END, 4'd3) |
        fld_byte({56'h0, `VCS_VAL_SLAVE_CHAR}, a, `VCS_OFF_SLAVE_CHAR, 4'd1) |
        fld_byte({56'h0, INTR_CAP}, a, `VCS_OFF_INTR_CAP, 4'd1) |
        fld_byte({56'h0, `VCS_VAL_ACC_W}, a, `VCS_OFF_F0_ACC_W, 4'd1) |
        fld_byte(`VCS_VAL_F0_AM_MASK, a, `VCS_OFF_F0_AM_MASK, 4'd8) |
        fld_byte({32'h0, F0_DEC_MASK}, a, `VCS_OFF_F0_DEC_MASK, 4'd4);
    end
  endfunction

  // Merges written bytes into a 32-bit register under the lane mask
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] m;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
      begin
        if (m[i])
        begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // Byte lanes of the cycle: D32, D16 or single byte
  always @*
  begin
    be = 4'h0;
    wd = data_in;
    if (!lword_n_in)
    begin
      be = 4'hF;
    end
    else
    begin
      wd = {data_in[15:0], data_in[15:0]};
      case (ds_n_in)
        2'b00: be = addr_q[1] ? 4'h3 : 4'hC;
        2'b10: be = addr_q[1] ? 4'h1 : 4'h4;
        2'b01: be = addr_q[1] ? 4'h2 : 4'h8;
        default: be = 4'h0;
      endcase
    end
  end

  // Read word; every unlisted location answers zero
  always @*
  begin
    rd_w = 32'h00000000;
    if (cfg_sel)
    begin
      if (cfg_byte <= `VCS_ROM_END)
      begin
        rd_w = {24'h000000, rom_byte(cfg_byte)};
      end
      else
      begin
        case (cfg_byte)
          `VCS_OFF_BASE_ADDR: rd_w = {24'h000000, base_addr_q};
          `VCS_OFF_BIT_SET: rd_w = {24'h000000, csr_bits_q};
          `VCS_OFF_BIT_CLEAR: rd_w = {24'h000000, csr_bits_q};
          `VCS_OFF_F0_COMPARE: rd_w = {24'h000000, f0_compare_q[31:24]};
          `VCS_OFF_F0_COMPARE + 19'h4: rd_w = {24'h000000, f0_compare_q[23:16]};
          `VCS_OFF_F0_COMPARE + 19'h8: rd_w = {24'h000000, f0_compare_q[15:8]};
          `VCS_OFF_F0_COMPARE + 19'hC: rd_w = {24'h000000, f0_compare_q[7:0]};
          default:
          begin
            // Only the mirrors live here, nothing operational
            case (cfg_word)
              `VCS_OFF_UNIT_NUM: rd_w = unit_number_in;
              `VCS_OFF_RST_PULSE: rd_w = 32'h00000000;
              `VCS_OFF_ADDR_CTL: rd_w = addressing_control_out;
              `VCS_OFF_STATUS: rd_w = status_snap_q;
              `VCS_OFF_FW_REV: rd_w = FW_REVISION;
              default: rd_w = 32'h00000000;
            endcase
          end
        endcase
      end
    end
    else
    begin
      case (nrm_word)
        `VCS_NRM_UNIT_NUM: rd_w = unit_number_in;
        `VCS_NRM_RST_PULSE: rd_w = 32'h00000000;
        `VCS_NRM_ADDR_CTL: rd_w = addressing_control_out;
        `VCS_NRM_STATUS: rd_w = status_snap_q;
        `VCS_NRM_FW_REV: rd_w = FW_REVISION;
        default: rd_w = 32'h00000000;
      endcase
    end
    if (!lword_n_in)
    begin
      rd_lane = rd_w;
    end
    else
    begin
      rd_lane = addr_q[1] ? {16'h0000, rd_w[15:0]} : {16'h0000, rd_w[31:16]};
    end
  end

  wire wr_pulse = wr && ((cfg_sel && cfg_word == `VCS_OFF_RST_PULSE) ||
                         (!cfg_sel && nrm_word == `VCS_NRM_RST_PULSE));
  wire wr_actl = wr && ((cfg_sel && cfg_word == `VCS_OFF_ADDR_CTL) ||
                        (!cfg_sel && nrm_word == `VCS_NRM_ADDR_CTL));
  wire [31:0] pulse_word = merge(32'h0, wd, be);
  wire [9:0] pulse_set = pulse_word[9:0] & `VCS_PULSE_VALID;

  // Address phase and cycle handshake
  always @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      state_q <= ST_IDLE;
      addr_q <= 32'h00000000;
      am_q <= 6'h00;
      as_prev_q <= 1'b1;
      status_snap_q <= `VCS_RST_WORD;
      data_out <= 32'h00000000;
      data_oe_out <= 1'b0;
      dtack_n_out <= 1'b1;
      dtack_oe_out <= 1'b0;
    end
    else
    begin
      as_prev_q <= as_n_in;
      dtack_n_out <= 1'b0;
      if (!as_n_in && as_prev_q)
      begin
        // Latch address and freeze status for a coherent read
        addr_q <= addr_in;
        am_q <= am_in;
        status_snap_q <= status_in;
      end
      case (state_q)
        ST_IDLE:
        begin
          if (go)
          begin
            state_q <= ST_ACK;
            dtack_oe_out <= 1'b1;
            data_out <= rd_lane;
            data_oe_out <= write_n_in;
          end
        end
        ST_ACK:
        begin
          if (!ds_act || as_n_in)
          begin
            dtack_oe_out <= 1'b0;
            data_oe_out <= 1'b0;
            // Block beats step the address; plain cycles wait for the next strobe
            if (is_blk && !as_n_in)
            begin
              addr_q <= addr_q + 32'h00000004;
              state_q <= ST_BLK;
            end
            else
            begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_BLK:
        begin
          if (as_n_in)
          begin
            state_q <= ST_IDLE;
          end
          else if (go)
          begin
            state_q <= ST_ACK;
            dtack_oe_out <= 1'b1;
            data_out <= rd_lane;
            data_oe_out <= write_n_in;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Register writes; status and ROM ignore them
  always @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      base_addr_q <= `VCS_RST_BYTE;
      csr_bits_q <= `VCS_RST_BYTE;
      f0_compare_q <= `VCS_RST_WORD;
      addressing_control_out <= `VCS_RST_WORD;
    end
    else if (wr && cfg_sel && be[0])
    begin
      case (cfg_byte)
        `VCS_OFF_BASE_ADDR: base_addr_q <= wd[7:0];
        `VCS_OFF_BIT_SET: csr_bits_q <= csr_bits_q | wd[7:0];
        `VCS_OFF_BIT_CLEAR: csr_bits_q <= csr_bits_q & ~wd[7:0];
        `VCS_OFF_F0_COMPARE: f0_compare_q[31:24] <= wd[7:0];
        `VCS_OFF_F0_COMPARE + 19'h4: f0_compare_q[23:16] <= wd[7:0];
        `VCS_OFF_F0_COMPARE + 19'h8: f0_compare_q[15:8] <= wd[7:0];
        `VCS_OFF_F0_COMPARE + 19'hC: f0_compare_q[7:0] <= wd[7:0];
        default:
        begin
          if (wr_actl)
          begin
            addressing_control_out <= merge(addressing_control_out, wd, be);
          end
        end
      endcase
    end
    else if (wr_actl)
    begin
      // Whole-cycle update so a reader never sees a half-written control word
      addressing_control_out <= merge(addressing_control_out, wd, be);
    end
  end

  // Reset pulses held for a fixed width; a new write setting a valid bit restarts the width
  always @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      reset_pulse_out <= 10'h000;
      pulse_cnt_q <= 4'h0;
    end
    else if (wr_pulse && (pulse_set != 10'h000))
    begin
      reset_pulse_out <= reset_pulse_out | pulse_set;
      pulse_cnt_q <= PULSE_LAST;
    end
    else if (pulse_cnt_q != 4'h0)
    begin
      pulse_cnt_q <= pulse_cnt_q - 4'h1;
    end
    else
    begin
      reset_pulse_out <= 10'h000;
    end
  end

endmodule // vcs_slave

// [include/vcs_defs.vh]
`ifndef VCS_DEFS_VH
`define VCS_DEFS_VH
// Behaviour
// - Every register except the pulse registers returns its contents when read; those are write-only.
// - Status registers ignore writes; control registers read back what was written.
// - Pulse registers always read as zero.
// - Control and status registers give coherent data during module updates.
// - Every access inside the decoded space ends with data acknowledge, never error.
// - All registers power up as zero unless a register states otherwise.
// - On-board memories are mapped straight into bus space.
// - Answer modifier 2F as configuration space, 09 single and 0B block A32.
// - Block transfers are meant only for memories and FIFO regions; the code also answers 0B block cycles at the normal-space register mirrors.
// - Configuration space spans 512 KB; user area sits at 7FBE0 to 7FBFF.
// - Configuration space accepts odd-byte, 16-bit and 32-bit cycles.
// - Reset pulses reachable from configuration space live in always-present logic.
// - ROM is read-only, one byte per fourth bus address.
// - Undefined bytes in ROM and CSR areas read as zero.
// - ROM reports access widths 84, space version 2 and the ASCII marker bytes.
// - Extended ROM holds user area bounds and slave characteristics 4.
// - Function 0 reports access width 84 and modifier mask A00.
// - Standard CSRs are bytes: base at 7FFFF, set 7FFFB, clear 7FFF7.
// - Four-byte function 0 compare register at 7FF63 to 7FF6F sets its decode.
// - User CSRs mirror the normal-space registers with identical behaviour.
// - Configuration space holds no operational registers beyond those mirrors.

// Address modifier codes
`define VCS_AM_CFG 6'h2F
`define VCS_AM_A32_SGL 6'h09
`define VCS_AM_A32_BLK 6'h0B

// Configuration space layout (byte addresses)
`define VCS_ROM_END 19'h00FFF
`define VCS_OFF_ROM_CHECKSUM 19'h00003
`define VCS_OFF_ROM_LENGTH 19'h00007
`define VCS_OFF_ROM_ACC_W 19'h00013
`define VCS_OFF_CSR_ACC_W 19'h00017
`define VCS_OFF_SPACE_VER 19'h0001B
`define VCS_OFF_ASCII_C 19'h0001F
`define VCS_OFF_ASCII_R 19'h00023
`define VCS_OFF_MAKER_ID 19'h00027
`define VCS_OFF_BOARD_IDENTIFIER 19'h00033
`define VCS_OFF_BOARD_REV 19'h00043
`define VCS_OFF_USER_START 19'h000B3
`define VCS_OFF_USER_END 19'h000BF
`define VCS_OFF_SLAVE_CHAR 19'h000E3
`define VCS_OFF_INTR_CAP 19'h000F7
`define VCS_OFF_F0_ACC_W 19'h00103
`define VCS_OFF_F0_AM_MASK 19'h00123
`define VCS_OFF_F0_DEC_MASK 19'h00623
`define VCS_OFF_UNIT_NUM 19'h7FBE0
`define VCS_OFF_RST_PULSE 19'h7FBE4
`define VCS_OFF_ADDR_CTL 19'h7FBE8
`define VCS_OFF_STATUS 19'h7FBEC
`define VCS_OFF_FW_REV 19'h7FBF0
`define VCS_OFF_F0_COMPARE 19'h7FF63
`define VCS_OFF_BIT_CLEAR 19'h7FFF7
`define VCS_OFF_BIT_SET 19'h7FFFB
`define VCS_OFF_BASE_ADDR 19'h7FFFF

// Normal A32 space mirrors (byte addresses, low 27 bits)
`define VCS_NRM_UNIT_NUM 27'h0000000
`define VCS_NRM_RST_PULSE 27'h0000008
`define VCS_NRM_ADDR_CTL 27'h0000010
`define VCS_NRM_STATUS 27'h0000014
`define VCS_NRM_FW_REV 27'h0000020

// Fixed ROM values
`define VCS_VAL_ACC_W 8'h84
`define VCS_VAL_SPACE_VER 8'h02
`define VCS_VAL_ASCII_C 8'h43
`define VCS_VAL_ASCII_R 8'h53
`define VCS_VAL_USER_START 24'h07FBE0
`define VCS_VAL_USER_END 24'h07FBFF
`define VCS_VAL_SLAVE_CHAR 8'h04
`define VCS_VAL_F0_AM_MASK 64'h0000000000000A00

// Field positions and reset values
`define VCS_BIT_MOD_ENABLE 4
`define VCS_RST_BYTE 8'h00
`define VCS_RST_WORD 32'h00000000
`define VCS_PULSE_VALID 10'h27F

// Reset pulse length
`define VCS_PULSE_NS 200
`define VCS_CLK_NS 20
`endif

// [tb/tb.sv]
`timescale 1ns/1ps
`include "vcs_defs.vh"
module tb;
  localparam [31:0] FW = 32'h0000A5C3; // Arbitrary value
  reg ref_clk_in = 1'b0;
  reg sys_rst_in = 1'b1;
  reg [4:0] ga_n_in = 5'h1A;
  reg [31:0] unit_number_in = 32'h00000000;
  reg [31:0] status_in = 32'h00000000;
  wire [31:0] addr_in, data_in, data_out, addressing_control_out;
  wire [5:0] am_in;
  wire [1:0] ds_n_in;
  wire as_n_in, lword_n_in, write_n_in, data_oe_out, dtack_n_out, dtack_oe_out;
  wire [9:0] reset_pulse_out;
  integer error_cnt = 0;
  integer n_tests = 0;
  integer i;
  reg [31:0] rd, v, cmp;
  reg [18:0] o;
  reg ack;
  // 50 MHz clock
  always #10 ref_clk_in = ~ref_clk_in;
  vcs_slave #(.FW_REVISION(FW)) vcs_slave_i (.ref_clk_in, .sys_rst_in, .addr_in, .am_in,
    .as_n_in, .lword_n_in, .write_n_in, .ds_n_in, .ga_n_in, .data_in, .data_out,
    .data_oe_out, .dtack_n_out, .dtack_oe_out, .unit_number_in, .status_in,
    .addressing_control_out, .reset_pulse_out);
  vcs_master vcs_master_i (.ref_clk_in, .dtack_oe_in(dtack_oe_out), .data_oe_in(data_oe_out),
    .rdata_in(data_out), .addr_out(addr_in), .am_out(am_in), .as_n_out(as_n_in),
    .lword_n_out(lword_n_in), .write_n_out(write_n_in), .ds_n_out(ds_n_in),
    .data_out(data_in));
  task summarize;
    begin
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task acc(input w, input [5:0] m, input [31:0] a, input lw, input [1:0] ds,
    input [31:0] wd, input ea);
    begin
      vcs_master_i.cycle(w, m, a, lw, ds, wd, rd, ack);
      check({31'h0, ack}, {31'h0, ea});
    end
  endtask
  // Slot address comes from the inverted geographic pins
  function [31:0] cfg(input [18:0] a);
    cfg = {8'h00, ~5'h1A, a};
  endfunction
  function [7:0] rom_exp(input [18:0] a);
    case (a)
      19'h13, 19'h17, 19'h103: rom_exp = 8'h84;
      19'h1B: rom_exp = 8'h02;
      19'h1F: rom_exp = 8'h43;
      19'h23: rom_exp = 8'h53;
      19'hB3, 19'hBF: rom_exp = 8'h07;
      19'hB7, 19'hC3: rom_exp = 8'hFB;
      19'hBB: rom_exp = 8'hE0;
      19'hC7: rom_exp = 8'hFF;
      19'hE3: rom_exp = 8'h04;
      19'h13B: rom_exp = 8'h0A;
      19'h2F, 19'h3F, 19'h4F: rom_exp = 8'h01; // Identity defaults
      default: rom_exp = 8'h00;
    endcase
  endfunction
  task bw(input [18:0] a, input [7:0] b);
    acc(1'b1, `VCS_AM_CFG, cfg(a), 1'b1, 2'b10, {24'h0, b}, 1'b1);
  endtask
  task br(input [18:0] a, input [7:0] e);
    begin
      acc(1'b0, `VCS_AM_CFG, cfg(a), 1'b1, 2'b10, 32'h0, 1'b1);
      check({24'h0, rd[7:0]}, {24'h0, e});
    end
  endtask
  task lw(input w, input [18:0] a, input [31:0] wd, input [31:0] e);
    begin
      acc(w, `VCS_AM_CFG, cfg(a), 1'b0, 2'b00, wd, 1'b1);
      if (!w)
        check(rd, e);
    end
  endtask
  // Watchdog well beyond the expected run of about 625 cycles
  initial
  begin
    #200000;
    error_cnt = error_cnt + 1;
    summarize;
  end
  initial
  begin
    v = $urandom(82400);
    repeat (12) @(posedge ref_clk_in);
    @(negedge ref_clk_in) sys_rst_in = 1'b0;
    lw(1'b0, 19'h7FBE8, 32'h0, 32'h0);
    check({31'h0, dtack_n_out}, 32'h0);
    check({31'h0, data_oe_out}, 32'h0);
    br(19'h7FFFF, 8'h00);
    br(19'h7FFFB, 8'h00);
    $display("test 1 done");
    for (i = 0; i < 80; i = i + 1)
    begin
      o = i * 4 + 3;
      br(o, rom_exp(o));
    end
    br(19'h623, 8'hF8);
    br(19'h7FC03, 8'h00);
    bw(19'h13, 8'hFF);
    br(19'h13, 8'h84);
    $display("test 2 done");
    v = $urandom;
    bw(19'h7FFFF, v[7:0]);
    br(19'h7FFFF, v[7:0]);
    bw(19'h7FFFB, 8'h10);
    br(19'h7FFFB, 8'h10);
    cmp = $urandom;
    for (i = 0; i < 4; i = i + 1)
      bw(19'h7FF63 + i * 4, cmp[31 - 8 * i -: 8]);
    for (i = 0; i < 4; i = i + 1)
      br(19'h7FF63 + i * 4, cmp[31 - 8 * i -: 8]);
    $display("test 3 done");
    unit_number_in = $urandom;
    status_in = $urandom;
    lw(1'b0, 19'h7FBE0, 32'h0, unit_number_in);
    lw(1'b1, 19'h7FBEC, 32'hFFFFFFFF, 32'h0);
    lw(1'b0, 19'h7FBEC, 32'h0, status_in);
    lw(1'b1, 19'h7FBF0, 32'h0, 32'h0);
    lw(1'b0, 19'h7FBF0, 32'h0, FW);
    v = $urandom;
    lw(1'b1, 19'h7FBE8, v, 32'h0);
    lw(1'b0, 19'h7FBE8, 32'h0, v);
    check(addressing_control_out, v);
    acc(1'b0, `VCS_AM_CFG, cfg(19'h7FBEC), 1'b1, 2'b00, 32'h0, 1'b1);
    check(rd, {16'h0, status_in[31:16]});
    acc(1'b0, `VCS_AM_CFG, cfg(19'h7FBEE), 1'b1, 2'b00, 32'h0, 1'b1);
    check(rd, {16'h0, status_in[15:0]});
    $display("test 4 done");
    lw(1'b1, 19'h7FBE4, 32'h000003FF, 32'h0);
    check({22'h0, reset_pulse_out}, {22'h0, `VCS_PULSE_VALID});
    lw(1'b0, 19'h7FBE4, 32'h0, 32'h0);
    repeat (10) @(negedge ref_clk_in);
    check({22'h0, reset_pulse_out}, 32'h0);
    lw(1'b1, 19'h7FBE4, 32'h0, 32'h0);
    check({22'h0, reset_pulse_out}, 32'h0);
    $display("test 5 done");
    status_in = $urandom;
    acc(1'b0, `VCS_AM_A32_SGL, {cmp[31:27], 27'h14}, 1'b0, 2'b00, 32'h0, 1'b1);
    check(rd, status_in);
    v = $urandom;
    acc(1'b1, `VCS_AM_A32_SGL, {cmp[31:27], 27'h10}, 1'b0, 2'b00, v, 1'b1);
    lw(1'b0, 19'h7FBE8, 32'h0, v);
    acc(1'b0, `VCS_AM_A32_BLK, {cmp[31:27], 27'h0}, 1'b0, 2'b00, 32'h0, 1'b1);
    check(rd, unit_number_in);
    acc(1'b0, `VCS_AM_A32_SGL, {~cmp[31:27], 27'h14}, 1'b0, 2'b00, 32'h0, 1'b0);
    bw(19'h7FFF7, 8'h10);
    acc(1'b0, `VCS_AM_A32_SGL, {cmp[31:27], 27'h14}, 1'b0, 2'b00, 32'h0, 1'b0);
    $display("test 6 done");
    summarize;
  end
endmodule // tb

// [tb/vcs_master.sv]
`timescale 1ns/1ps
module vcs_master (
  // Clock
  input wire ref_clk_in,
  // Device answer
  input wire dtack_oe_in,
  input wire data_oe_in,
  input wire [31:0] rdata_in,
  // Bus request
  output reg [31:0] addr_out = 32'hFFFFFFFF,
  output reg [5:0] am_out = 6'h3F,
  output reg as_n_out = 1'b1,
  output reg lword_n_out = 1'b1,
  output reg write_n_out = 1'b1,
  output reg [1:0] ds_n_out = 2'b11,
  output wire [31:0] data_out
);
  reg [31:0] wdat = 32'h00000000;
  reg drv = 1'b0;
  // Released lines show the inverse so a stale value cannot pass
  assign data_out = data_oe_in ? rdata_in : (drv ? wdat : ~wdat);
  // One beat; everything held until acknowledge is sampled high, or for at most eight clocks
  task cycle(input w, input [5:0] m, input [31:0] a, input lw, input [1:0] ds,
    input [31:0] wd, output [31:0] rd, output ack);
    integer n;
    begin
      @(negedge ref_clk_in);
      addr_out = a;
      am_out = m;
      write_n_out = ~w;
      lword_n_out = lw;
      wdat = wd;
      drv = w;
      as_n_out = 1'b0;
      @(negedge ref_clk_in);
      ds_n_out = ds;
      ack = 1'b0;
      for (n = 0; n < 8 && !ack; n = n + 1)
      begin
        @(posedge ref_clk_in);
        ack = (dtack_oe_in === 1'b1);
      end
      rd = rdata_in;
      @(negedge ref_clk_in);
      ds_n_out = 2'b11;
      as_n_out = 1'b1;
      drv = 1'b0;
      addr_out = ~a;
      @(negedge ref_clk_in);
    end
  endtask
endmodule // vcs_master

// [tb/vcs_slave_chk.sv]
`timescale 1ns/1ps
`include "vcs_defs.vh"
module vcs_slave_chk (
  // Clock and reset
  input wire ref_clk_in,
  input wire sys_rst_in,
  // Bus side
  input wire [31:0] addr_in,
  input wire [5:0] am_in,
  input wire as_n_in,
  input wire lword_n_in,
  input wire write_n_in,
  input wire [1:0] ds_n_in,
  input wire [4:0] ga_n_in,
  input wire [31:0] data_in,
  input wire [31:0] data_out,
  input wire data_oe_out,
  input wire dtack_n_out,
  input wire dtack_oe_out,
  // Module side
  input wire [31:0] unit_number_in,
  input wire [31:0] status_in,
  input wire [31:0] addressing_control_out,
  input wire [9:0] reset_pulse_out
);
  // Any pulse bit active
  wire pulse_on = |reset_pulse_out;
  default clocking dc @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  chk_ack_low: assert property (dtack_oe_out |-> !dtack_n_out)
    else $error("acknowledge enabled but not driven low");
  chk_ack_cause: assert property ($rose(dtack_oe_out) |->
    ds_n_in != 2'b11 && !as_n_in && $past(!as_n_in))
    else $error("acknowledge without a strobed cycle");
  chk_ack_release: assert property (dtack_oe_out && ds_n_in == 2'b11 |=> !dtack_oe_out)
    else $error("acknowledge held after strobes released");
  chk_idle_quiet: assert property (as_n_in && $past(as_n_in) |-> !dtack_oe_out)
    else $error("acknowledge while bus idle");
  chk_read_drive: assert property (data_oe_out |-> dtack_oe_out && write_n_in)
    else $error("data driven outside a read answer");
  chk_pulse_read: assert property (data_oe_out && am_in == `VCS_AM_CFG &&
    addr_in[18:0] == 19'h7FBE4 |-> data_out == 32'h00000000)
    else $error("pulse register read nonzero");
  // Ten cycles of 20 ns make the documented 200 ns pulse
  chk_pulse_width: assert property ($rose(pulse_on) |->
    pulse_on [*8] ##1 pulse_on ##1 pulse_on ##1 !pulse_on)
    else $error("pulse width not ten cycles");
  chk_pulse_cause: assert property ($rose(pulse_on) |-> $rose(dtack_oe_out) && !write_n_in)
    else $error("pulse without a write");
  chk_pulse_mask: assert property ((reset_pulse_out & ~`VCS_PULSE_VALID) == 10'h000)
    else $error("undefined pulse bit active");
  chk_ctl_cause: assert property ($changed(addressing_control_out) |->
    $rose(dtack_oe_out) && !write_n_in)
    else $error("control register changed without a write");
  cov_pulse: cover property ($rose(pulse_on));
  cov_read: cover property ($rose(data_oe_out));
  cov_write: cover property ($rose(dtack_oe_out) && !write_n_in);
endmodule // vcs_slave_chk

bind vcs_slave vcs_slave_chk vcs_slave_chk_i (.ref_clk_in, .sys_rst_in, .addr_in, .am_in,
  .as_n_in, .lword_n_in, .write_n_in, .ds_n_in, .ga_n_in, .data_in, .data_out, .data_oe_out,
  .dtack_n_out, .dtack_oe_out, .unit_number_in, .status_in, .addressing_control_out,
  .reset_pulse_out);
